// file: include/sfwp_pkg.sv
package sfwp_pkg;

  // Command opcodes
  typedef enum logic [7:0] {
    OP_WRITE_ENABLE   = 8'h06,
    OP_WRITE_DISABLE  = 8'h04,
    OP_WRITE_REGS     = 8'h01,
    OP_WRITE_ANY_REG  = 8'h71,
    OP_CLEAR_STATUS   = 8'h30,
    OP_PAGE_PROGRAM   = 8'h02,
    OP_SECTOR_ERASE   = 8'hD8,
    OP_PARAM_ERASE    = 8'h20,
    OP_BULK_ERASE     = 8'h60,
    OP_OTP_PROGRAM    = 8'h42,
    OP_OTP_READ       = 8'h4B,
    OP_GUARD_PROGRAM  = 8'h2F,
    OP_PERSIST_PROG   = 8'hE3,
    OP_PERSIST_ERASE  = 8'hE4,
    OP_PERSIST_READ   = 8'hE2,
    OP_LOCK_CLEAR     = 8'hA6,
    OP_PASS_PROGRAM   = 8'hE8,
    OP_PASS_UNLOCK    = 8'hE9,
    OP_DYN_WRITE      = 8'hFB,
    OP_DYN_READ       = 8'hFA,
    OP_LEARN_PROGRAM  = 8'h43,
    OP_SOFT_RESET     = 8'hF0
  } sfwp_op_t;

  // Command from the link
  typedef struct packed {
    sfwp_op_t    op;
    logic [23:0] addr;
    logic [63:0] data;
  } sfwp_cmd_t;

  // Answer to the link
  typedef struct packed {
    logic [7:0] rd_data;
    logic       ecc_on;
    logic       refused;
    logic       p_err;
    logic       e_err;
  } sfwp_rsp_t;

  // Protection state shown to the system
  typedef struct packed {
    logic       write_enable_latch;
    logic       p_err;
    logic       e_err;
    logic       status_write_disable;
    logic [2:0] bp;
    logic       tb;
    logic       freeze;
    logic       lock;
    logic [1:0] mode;
  } sfwp_stat_t;

  // Grant to the main array engine
  typedef struct packed {
    logic        erase;
    logic        bulk;
    logic [23:0] addr;
  } sfwp_grant_t;

endpackage

// file: include/sfwp_regs.svh
`ifndef SFWP_REGS_SVH
`define SFWP_REGS_SVH

// OTP space geometry
`define SFWP_OTP_BYTES       11'h400
`define SFWP_OTP_REGIONS     32
`define SFWP_OTP_REGION_SZ   32
`define SFWP_ECC_PORTION     16
`define SFWP_ECC_PORTIONS    64
`define SFWP_LOCK_BASE       10'h010
`define SFWP_OTP_ERASED      8'hFF

// Main array geometry (64 KB sectors, 8192 KB array)
`define SFWP_SECTORS         128
`define SFWP_SECTOR_MSB      22
`define SFWP_SECTOR_LSB      16

// Status register 1 field positions
`define SFWP_SR1_STATUS_WRITE_DISABLE_BIT    7
`define SFWP_SR1_BP_MSB      4
`define SFWP_SR1_BP_LSB      2

// Config register 1 field positions (in data[15:8] of a register write)
`define SFWP_CR1_TB_BIT      13
`define SFWP_CR1_FREEZE_BIT  8

// Guard mode register select field
`define SFWP_MODE_MSB        2
`define SFWP_MODE_LSB        1

// Reset values
`define SFWP_MODE_RESET      2'h3
`define SFWP_PASS_RESET      64'hFFFF_FFFF_FFFF_FFFF
`define SFWP_BP_RESET        3'h0
`define SFWP_TB_RESET        1'h0

`endif

// file: tb/sfwp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfwp_host_model (
  // Link clock
  input  wire logic                sclk,
  // Command channel
  output var  logic                cmd_valid,
  output var  sfwp_pkg::sfwp_cmd_t cmd,
  input  wire logic                cmd_ready,
  // Answer channel
  input  wire logic                rsp_valid,
  input  wire sfwp_pkg::sfwp_rsp_t rsp
);
  // Idle until the first command
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // Offer one command, hold it until taken, then collect the answer
  task automatic send(input logic [7:0] op, input logic [23:0] a, input logic [63:0] d,
                      output sfwp_pkg::sfwp_rsp_t r);
    int n;
    n = 0;
    @(posedge sclk);
    cmd_valid <= 1'b1;
    cmd       <= {op, a, d};
    do @(posedge sclk); while (!cmd_ready && n++ < 200);
    cmd_valid <= 1'b0;
    // Released lines flip so a stale command never looks fresh
    cmd       <= ~{op, a, d};
    do @(posedge sclk); while (!rsp_valid && n++ < 400);
    // A missing answer reads as unknown, so every check of it fails
    if (rsp_valid) r = rsp;
    else r = 'x;
  endtask
endmodule // sfwp_host_model
`default_nettype wire

// file: tb/sfwp_protect_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sfwp_protect_properties (
  // Clocks, reset and pins
  input wire logic                  mclk,
  input wire logic                  arst_n,
  input wire logic                  hw_reset_n,
  input wire logic                  wp_n,
  input wire logic                  sclk,
  // Link side
  input wire logic                  cmd_valid,
  input wire sfwp_pkg::sfwp_cmd_t   cmd,
  input wire logic                  cmd_ready,
  input wire logic                  rsp_valid,
  input wire sfwp_pkg::sfwp_rsp_t   rsp,
  // System side
  input wire sfwp_pkg::sfwp_stat_t  stat,
  input wire logic                  array_go,
  input wire sfwp_pkg::sfwp_grant_t array_grant
);
  // Everything watched here lives on the system clock
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Sector falls inside the range chosen by the range bits
  function automatic logic in_range(logic [2:0] bp, logic tb, logic [23:0] a);
    logic [7:0] n;
    n = (bp == 3'h0) ? 8'h00 : (8'h01 << bp);
    return tb ? ({1'b0, a[22:16]} < n) : ({1'b0, a[22:16]} >= 8'h80 - n);
  endfunction

  bulk_clear_a: assert property (array_go && array_grant.bulk |-> stat.bp == 3'h0)
    else $error("bulk erase granted with range bits set");
  range_guard_a: assert property (array_go && !array_grant.bulk |-> !in_range(stat.bp, stat.tb, array_grant.addr))
    else $error("array access granted inside protected range");
  latch_drop_a: assert property (array_go |-> ##[0:4] !stat.write_enable_latch)
    else $error("write enable latch kept after array access");
  latch_needed_a: assert property (array_go |-> $past(stat.write_enable_latch, 3))
    else $error("array access granted without write enable");
  freeze_hold_a: assert property ($past(stat.freeze) |-> $stable(stat.bp) && $stable(stat.tb))
    else $error("range bits changed while frozen");
  freeze_sticky_a: assert property (!$fell(stat.freeze))
    else $error("freeze bit cleared without power cycle");
  mode_legal_a: assert property (stat.mode != 2'h0)
    else $error("illegal lock method code");
  mode_fixed_a: assert property ($past(stat.mode) != 2'h3 |-> $stable(stat.mode))
    else $error("lock method changed after selection");
  boot_lock_a: assert property ($rose(stat.lock) && stat.mode != 2'h1 |->
      !$past(hw_reset_n, 2) || !$past(hw_reset_n, 3) || !$past(hw_reset_n, 4))
    else $error("lock set by command in boot method");
  hold_reset_a: assert property (!hw_reset_n [*5] |-> !stat.write_enable_latch && stat.lock == (stat.mode != 2'h1))
    else $error("wrong latch or lock during hardware reset");
endmodule // sfwp_protect_properties
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                  mclk = 0, sclk = 0, arst_n = 0, hw_reset_n = 1, wp_n = 1;
  logic                  cmd_valid, cmd_ready, rsp_valid, array_go;
  sfwp_pkg::sfwp_cmd_t   cmd;
  sfwp_pkg::sfwp_rsp_t   rsp, rr;
  sfwp_pkg::sfwp_stat_t  stat;
  sfwp_pkg::sfwp_grant_t array_grant;
  int                    fail_count = 0, n_tests = 0, n_go = 0;
  logic [63:0]           pw = 64'h0123_4567_89AB_CDEF;
  // Rows: op, addr, data, flags {write_enable_cmd, refused, p_err, e_err, go}
  logic [55:0] rows [] = '{
    56'h02_000000_0000_08,
    56'h02_000000_0000_11,
    56'h01_000000_0004_10,
    56'h02_7F0000_0000_14,
    56'h02_7D0000_0000_11,
    56'hD8_7E0000_0000_12,
    56'h01_000000_2004_10,
    56'h20_010000_0000_12,
    56'hD8_7F0000_0000_11,
    56'h01_000000_001C_10,
    56'h02_400000_0000_14,
    56'h01_000000_0000_10,
    56'hFB_050000_0000_10,
    56'h02_050000_0000_14,
    56'hFB_050000_0001_10,
    56'h02_050000_0000_11,
    56'hE3_060000_0000_10,
    56'hD8_060000_0000_12,
    56'h60_000000_0000_12,
    56'hE4_000000_0000_10,
    56'h60_000000_0000_11,
    56'hA6_000000_0000_10,
    56'hE3_060000_0000_14,
    56'hE4_000000_0000_12,
    56'hE9_000000_0000_18,
    56'h42_000020_005A_10,
    56'h4B_000020_115A_00,
    56'h42_000020_000F_10,
    56'h4B_000020_100A_00,
    56'h42_0003FF_00C3_10,
    56'h4B_0003FF_11C3_00,
    56'h42_000400_0000_10,
    56'h4B_000400_00FF_00,
    56'h42_000011_00FE_10,
    56'h42_000100_0000_14,
    56'h4B_000100_00FF_00,
    56'h42_000010_00FE_10,
    56'h42_00001F_0000_14,
    56'h42_000005_0000_10
  };

  // Clocks of unrelated phase
  always #2.5 mclk = ~mclk;
  always #3 sclk = ~sclk;
  // Count permitted array accesses
  always @(posedge mclk) if (array_go === 1'b1) n_go <= n_go + 1;

  sfwp_protect dut (.mclk(mclk), .arst_n(arst_n), .hw_reset_n(hw_reset_n), .wp_n(wp_n), .sclk(sclk),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .stat(stat), .array_go(array_go), .array_grant(array_grant));
  sfwp_host_model host (.sclk(sclk), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp(rsp));

  // Compare and report
  task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
    n_tests++;
    if (exp !== got) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One command with optional write enable, answer checked, errors cleared
  task automatic run(logic [7:0] op, logic [23:0] a, logic [63:0] d, logic [7:0] e);
    sfwp_pkg::sfwp_rsp_t r;
    int g;
    if (e[4]) host.send(8'h06, 24'h0, 64'h0, r);
    g = n_go;
    host.send(op, a, d, r);
    repeat (2) @(posedge mclk);
    if (op == 8'h4B) begin
      chk("rd_data", d[7:0], r.rd_data);
      if (d[12]) chk("ecc_on", d[8], r.ecc_on);
    end else begin
      chk("refused", e[3], r.refused);
      chk("p_err", e[2], r.p_err);
      chk("e_err", e[1], r.e_err);
      chk("array_go", e[0], n_go != g);
      if (e[0] && op != 8'h60) chk("grant", a, array_grant.addr);
      if (e[0]) chk("erase", op != 8'h02, array_grant.erase);
      if (e[0]) chk("bulk", op == 8'h60, array_grant.bulk);
      if (e[4] && !e[3]) chk("wel", 0, stat.write_enable_latch);
      host.send(8'h30, 24'h0, 64'h0, r);
    end
  endtask
  // Pulse the hardware reset pin and look inside the pulse
  task automatic hwrst(logic lk);
    @(posedge mclk);
    hw_reset_n <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("wel", 0, stat.write_enable_latch);
    chk("lock", lk, stat.lock);
    hw_reset_n <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask
  // Power-on reset for eight cycles
  task automatic por();
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("mode", 2'h3, stat.mode);
    chk("lock", 1, stat.lock);
    chk("wel", 0, stat.write_enable_latch);
  endtask
  // Drive the write protect pin and let it settle
  task automatic set_wp(logic v);
    @(posedge mclk);
    wp_n <= v;
    repeat (4) @(posedge mclk);
  endtask
  // Verdict and end of run
  task automatic give_verdict();
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    por();
    foreach (rows[i]) run(rows[i][55:48], rows[i][47:24], rows[i][23:8], rows[i][7:0]);
    run(8'h01, 24'h0, 64'h0080, 8'h10);
    set_wp(1'b0);
    run(8'h01, 24'h0, 64'h0004, 8'h14);
    chk("bp", 3'h0, stat.bp);
    set_wp(1'b1);
    run(8'h01, 24'h0, 64'h0104, 8'h10);
    chk("freeze", 1, stat.freeze);
    run(8'h42, 24'h40, 64'h0, 8'h14);
    run(8'h42, 24'h400, 64'h0, 8'h10);
    run(8'h01, 24'h0, 64'h0100, 8'h14);
    chk("bp", 3'h1, stat.bp);
    host.send(8'h06, 24'h0, 64'h0, rr);
    hwrst(1'b1);
    chk("freeze", 1, stat.freeze);
    run(8'hE8, 24'h0, pw, 8'h10);
    run(8'h2F, 24'h0, 64'h1, 8'h14);
    run(8'h2F, 24'h0, 64'h3, 8'h10);
    chk("mode", 2'h1, stat.mode);
    run(8'hE8, 24'h0, pw, 8'h14);
    run(8'h2F, 24'h0, 64'h5, 8'h14);
    hwrst(1'b0);
    run(8'hE9, 24'h0, ~pw, 8'h04);
    chk("lock", 0, stat.lock);
    run(8'hE9, 24'h0, pw, 8'h00);
    chk("lock", 1, stat.lock);
    run(8'hA6, 24'h0, 64'h0, 8'h10);
    chk("lock", 0, stat.lock);
    por();
    chk("freeze", 0, stat.freeze);
    run(8'h2F, 24'h0, 64'h5, 8'h10);
    chk("mode", 2'h2, stat.mode);
    run(8'hA6, 24'h0, 64'h0, 8'h10);
    hwrst(1'b1);
    give_verdict();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
endmodule // testbench

bind sfwp_protect sfwp_protect_properties u_props (.mclk(mclk), .arst_n(arst_n), .hw_reset_n(hw_reset_n),
  .wp_n(wp_n), .sclk(sclk), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
  .rsp(rsp), .stat(stat), .array_go(array_go), .array_grant(array_grant));
`default_nettype wire

// file: verilog/sfwp_protect.sv
// Overview of operation
// - OTP space 1024 bytes, 32 lockable regions
// - OTP read; out-of-range returns erased pattern 0xFF
// - OTP reprogrammable, never erasable
// - ECC per 16 bytes, lost on reprogram
// - Out-of-range OTP program silently ignored
// - OTP program under freeze sets program error
// - Freeze locks range bits and OTP
// - Lock byte bit n guards region n
// - Region zero lock guards its upper half
// - Modifying commands need write enable latch
// - Latch cleared at reset and command completion
// - Range protection, top or bottom select
// - Range code sets protected size
// - Select zero top, one bottom
// - Sector protected by range OR sector guard
// - Pin low plus disable bit blocks register writes
// - Persistent or dynamic bit zero protects sector
// - Persistent bits frozen while lock is zero
// - Boot mode: lock set at reset, clearable
// - Boot mode: lock never set by command
// - Password mode: match sets lock, reset clears
// - Guard mode register picks lock method
// - Mode bits 11 default, 10 boot, 01 password
// - Dynamic write sets or clears dynamic bit
`timescale 1ns/1ps
`default_nettype none
`include "sfwp_regs.svh"

module sfwp_protect (
  // System clock and power-on reset
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  // Device pins
  input  wire logic                 hw_reset_n,
  input  wire logic                 wp_n,
  // Link side, on the serial clock
  input  wire logic                 sclk,
  input  wire logic                 cmd_valid,
  input  wire sfwp_pkg::sfwp_cmd_t  cmd,
  output var  logic                 cmd_ready,
  output var  logic                 rsp_valid,
  output var  sfwp_pkg::sfwp_rsp_t  rsp,
  // System side, on mclk
  output var  sfwp_pkg::sfwp_stat_t stat,
  output var  logic                 array_go,
  output var  sfwp_pkg::sfwp_grant_t array_grant
);

  // Range code to coverage of one 64 KB sector
  function automatic logic bp_covers(input logic [6:0] sec, input logic [2:0] bp, input logic tb);
    logic [7:0] n;
    n = (bp == 3'h0) ? 8'h00 : (8'h01 << bp);
    if (tb) bp_covers = ({1'b0, sec} < n);
    else    bp_covers = ({1'b0, sec} >= (8'h80 - n));
  endfunction

  // ---------------- Link domain ----------------
  sfwp_pkg::sfwp_cmd_t hold_q,    hold_d;     // Command held for mclk
  logic                req_tog_q, req_tog_d;  // Request toggle
  logic                busy_q,    busy_d;     // Waiting for answer
  logic                ready_q,   ready_d;    // Ready to the host
  logic                rv_q,      rv_d;       // Answer strobe
  sfwp_pkg::sfwp_rsp_t rsp_l_q,   rsp_l_d;    // Answer to host
  logic                ack_s1_q;              // Ack sync stage 1
  logic                ack_s2_q;              // Ack sync stage 2
  logic                ack_s3_q;              // Ack edge reference

  // ---------------- mclk domain ----------------
  logic                ack_tog_q, ack_tog_d;  // Answer toggle
  logic                req_s1_q;              // Request sync stage 1
  logic                req_s2_q;              // Request sync stage 2
  logic                req_s3_q;              // Request edge reference
  logic                wp_s1_q,   wp_s2_q;    // Pin sync
  logic                hwr_s1_q,  hwr_s2_q;   // Pin sync
  sfwp_pkg::sfwp_rsp_t rsp_m_q,   rsp_m_d;    // Answer held for link
  sfwp_pkg::sfwp_stat_t st_q,     st_d;       // Protection state
  logic [63:0]         pass_q,    pass_d;     // Hidden password
  logic [127:0]        ppb_q,     ppb_d;      // Persistent sector bits
  logic [127:0]        dyb_q,     dyb_d;      // Dynamic sector bits
  logic [63:0]         ecc_once_q, ecc_once_d; // Portion programmed once
  logic [63:0]         ecc_off_q, ecc_off_d;  // Portion lost its ECC
  logic                go_q,      go_d;       // Array grant strobe
  sfwp_pkg::sfwp_grant_t grant_q, grant_d;    // Array grant detail
  logic [7:0]          otp_mem [0:1023];      // OTP byte store
  logic                otp_we;                // OTP write strobe
  logic [9:0]          otp_wa;                // OTP write address
  logic [7:0]          otp_wd;                // OTP write data

  // Link domain: take a command, wait for the answer toggle
  always_comb begin
    hold_d    = hold_q;
    req_tog_d = req_tog_q;
    busy_d    = busy_q;
    rv_d      = 1'b0;
    rsp_l_d   = rsp_l_q;
    if (busy_q && (ack_s2_q != ack_s3_q)) begin
      // Answer is stable in mclk register since the edge the toggle moved
      busy_d  = 1'b0;
      rv_d    = 1'b1;
      rsp_l_d = rsp_m_q;
    end else if (!busy_q && cmd_valid) begin
      hold_d    = cmd;
      req_tog_d = ~req_tog_q;
      busy_d    = 1'b1;
    end
    // Ready follows the next busy state, so it falls at the take edge
    ready_d = ~busy_d;
  end

  // Link domain registers
  always_ff @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      hold_q    <= '0;
      req_tog_q <= 1'b0;
      busy_q    <= 1'b0;
      ready_q   <= 1'b0;
      rv_q      <= 1'b0;
      rsp_l_q   <= '0;
      ack_s1_q  <= 1'b0;
      ack_s2_q  <= 1'b0;
      ack_s3_q  <= 1'b0;
    end else begin
      hold_q    <= hold_d;
      req_tog_q <= req_tog_d;
      busy_q    <= busy_d;
      ready_q   <= ready_d;
      rv_q      <= rv_d;
      rsp_l_q   <= rsp_l_d;
      ack_s1_q  <= ack_tog_q;
      ack_s2_q  <= ack_s1_q;
      ack_s3_q  <= ack_s2_q;
    end
  end

  // Synchronisers into mclk
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      wp_s1_q  <= 1'b1;
      wp_s2_q  <= 1'b1;
      hwr_s1_q <= 1'b1;
      hwr_s2_q <= 1'b1;
    end else begin
      req_s1_q <= req_tog_q;
      req_s2_q <= req_s1_q;
      // Edge reference waits while the reset pin is low, so a request is held
      req_s3_q <= hwr_s2_q ? req_s2_q : req_s3_q;
      wp_s1_q  <= wp_n;
      wp_s2_q  <= wp_s1_q;
      hwr_s1_q <= hw_reset_n;
      hwr_s2_q <= hwr_s1_q;
    end
  end

  // Command execution
  always_comb begin
    logic       req_p;
    logic [6:0] sec;
    logic       sec_prot;
    logic       any_prot;
    logic [9:0] oa;
    logic [4:0] reg_idx;
    logic       locked;
    logic [1:0] new_mode;
    logic       modifying;
    req_p     = (req_s2_q != req_s3_q);
    sec       = hold_q.addr[`SFWP_SECTOR_MSB:`SFWP_SECTOR_LSB];
    // Sector is closed if the range or either guard bit says so
    sec_prot  = bp_covers(sec, st_q.bp, st_q.tb)
                | ~ppb_q[sec] | ~dyb_q[sec];
    any_prot  = (st_q.bp != 3'h0) | ~(&ppb_q) | ~(&dyb_q);
    oa        = hold_q.addr[9:0];
    reg_idx   = oa[9:5];
    // Lock bits live in bytes 0x10..0x13; bit n guards region n
    // Erased lock bit reads one and leaves its region open
    locked    = ~otp_mem[`SFWP_LOCK_BASE + {8'h00, reg_idx[4:3]}][reg_idx[2:0]];
    // Region zero lock spares the factory lower 16 bytes
    if (reg_idx == 5'h00) locked = locked & oa[4];
    // Mode bits only fall, like any one-time bit
    new_mode  = st_q.mode & hold_q.data[`SFWP_MODE_MSB:`SFWP_MODE_LSB];
    modifying = 1'b0;
    st_d       = st_q;
    pass_d     = pass_q;
    ppb_d      = ppb_q;
    dyb_d      = dyb_q;
    ecc_once_d = ecc_once_q;
    ecc_off_d  = ecc_off_q;
    rsp_m_d    = rsp_m_q;
    ack_tog_d  = ack_tog_q;
    go_d       = 1'b0;
    grant_d    = grant_q;
    otp_we     = 1'b0;
    otp_wa     = oa;
    // Programming only clears bits of the stored byte
    otp_wd     = otp_mem[oa] & hold_q.data[7:0];
    if (!hwr_s2_q) begin
      // Hardware reset: volatile state only; freeze survives
      // A request arriving now waits unanswered until the pin rises
      st_d.write_enable_latch  = 1'b0;
      dyb_d     = '1;
      st_d.lock = (st_q.mode != 2'h1);
    end else if (req_p) begin
      ack_tog_d = ~ack_tog_q;
      // Each answer starts clean; each command fills its fields
      rsp_m_d   = '0;
      case (hold_q.op)
        sfwp_pkg::OP_WRITE_ENABLE: begin
          st_d.write_enable_latch = 1'b1;
        end
        sfwp_pkg::OP_CLEAR_STATUS: begin
          st_d.p_err = 1'b0;
          st_d.e_err = 1'b0;
        end
        sfwp_pkg::OP_OTP_READ: begin
          // Beyond 1 KB reads erased pattern
          rsp_m_d.rd_data = (hold_q.addr < {13'h0000, `SFWP_OTP_BYTES}) ? otp_mem[oa]
                            : `SFWP_OTP_ERASED;
          rsp_m_d.ecc_on  = ~ecc_off_q[oa[9:4]];
        end
        sfwp_pkg::OP_PERSIST_READ: begin
          rsp_m_d.rd_data = {8{ppb_q[sec]}};
        end
        sfwp_pkg::OP_DYN_READ: begin
          rsp_m_d.rd_data = {8{dyb_q[sec]}};
        end
        sfwp_pkg::OP_PASS_UNLOCK: begin
          if (st_q.mode == 2'h1 && hold_q.data == pass_q)
            st_d.lock = 1'b1;
          else if (st_q.mode == 2'h1)
            st_d.p_err = 1'b1;
          else
            rsp_m_d.refused = 1'b1;
        end
        default: begin
          modifying = 1'b1;
        end
      endcase
      if (modifying && !st_q.write_enable_latch) begin
        rsp_m_d.refused = 1'b1;
      end else if (modifying) begin
        st_d.write_enable_latch = 1'b0;
        case (hold_q.op)
          sfwp_pkg::OP_PAGE_PROGRAM: begin
            if (sec_prot) st_d.p_err = 1'b1;
            else go_d = 1'b1;
            grant_d = '{erase: 1'b0, bulk: 1'b0, addr: hold_q.addr};
          end
          sfwp_pkg::OP_SECTOR_ERASE, sfwp_pkg::OP_PARAM_ERASE: begin
            if (sec_prot) st_d.e_err = 1'b1;
            else go_d = 1'b1;
            grant_d = '{erase: 1'b1, bulk: 1'b0, addr: hold_q.addr};
          end
          sfwp_pkg::OP_BULK_ERASE: begin
            if (any_prot) st_d.e_err = 1'b1;
            else go_d = 1'b1;
            grant_d = '{erase: 1'b1, bulk: 1'b1, addr: 24'h000000};
          end
          sfwp_pkg::OP_WRITE_REGS, sfwp_pkg::OP_WRITE_ANY_REG: begin
            if (!wp_s2_q && st_q.status_write_disable) begin
              st_d.p_err = 1'b1;
            end else if (st_q.freeze &&
                         (hold_q.data[`SFWP_SR1_BP_MSB:`SFWP_SR1_BP_LSB] != st_q.bp ||
                          hold_q.data[`SFWP_CR1_TB_BIT] != st_q.tb)) begin
              st_d.p_err = 1'b1;
            end else begin
              st_d.status_write_disable   = hold_q.data[`SFWP_SR1_STATUS_WRITE_DISABLE_BIT];
              st_d.bp     = hold_q.data[`SFWP_SR1_BP_MSB:`SFWP_SR1_BP_LSB];
              st_d.tb     = hold_q.data[`SFWP_CR1_TB_BIT];
              // Freeze can only be set; cleared by power cycle
              st_d.freeze = st_q.freeze | hold_q.data[`SFWP_CR1_FREEZE_BIT];
            end
          end
          sfwp_pkg::OP_OTP_PROGRAM: begin
            if (hold_q.addr >= {13'h0000, `SFWP_OTP_BYTES}) begin
              // Outside valid space: no effect, no error
            end else if (st_q.freeze) begin
              st_d.p_err = 1'b1;
            end else if (locked) begin
              st_d.p_err = 1'b1;
            end else begin
              otp_we = 1'b1;
              ecc_once_d[oa[9:4]] = 1'b1;
              if (ecc_once_q[oa[9:4]]) ecc_off_d[oa[9:4]] = 1'b1;
            end
          end
          sfwp_pkg::OP_GUARD_PROGRAM: begin
            // Selection is one-time; both bits zero is illegal
            if (st_q.mode != `SFWP_MODE_RESET || new_mode == 2'h0)
              st_d.p_err = 1'b1;
            else
              st_d.mode = new_mode;
          end
          sfwp_pkg::OP_PASS_PROGRAM: begin
            if (st_q.mode != `SFWP_MODE_RESET) st_d.p_err = 1'b1;
            else pass_d = hold_q.data;
          end
          sfwp_pkg::OP_PERSIST_PROG: begin
            if (!st_q.lock) st_d.p_err = 1'b1;
            else ppb_d[sec] = 1'b0;
          end
          sfwp_pkg::OP_PERSIST_ERASE: begin
            if (!st_q.lock) st_d.e_err = 1'b1;
            else ppb_d = '1;
          end
          sfwp_pkg::OP_LOCK_CLEAR: begin
            st_d.lock = 1'b0;
          end
          sfwp_pkg::OP_DYN_WRITE: begin
            dyb_d[sec] = hold_q.data[0];
          end
          default: begin
            // Disable, reset, learning program: latch clear only
          end
        endcase
      end
      // Answer carries the sticky error flags as they stand after this command
      rsp_m_d.p_err = st_d.p_err;
      rsp_m_d.e_err = st_d.e_err;
    end
  end

  // Protection state registers; nonvolatile bits reset only on power-on
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q       <= '{write_enable_latch: 1'b0, p_err: 1'b0, e_err: 1'b0, status_write_disable: 1'b0,
                      bp: `SFWP_BP_RESET, tb: `SFWP_TB_RESET, freeze: 1'b0,
                      lock: 1'b1, mode: `SFWP_MODE_RESET};
      pass_q     <= `SFWP_PASS_RESET;
      ppb_q      <= '1;
      dyb_q      <= '1;
      ecc_once_q <= '0;
      ecc_off_q  <= '0;
      rsp_m_q    <= '0;
      ack_tog_q  <= 1'b0;
      go_q       <= 1'b0;
      grant_q    <= '0;
    end else begin
      st_q       <= st_d;
      pass_q     <= pass_d;
      ppb_q      <= ppb_d;
      dyb_q      <= dyb_d;
      ecc_once_q <= ecc_once_d;
      ecc_off_q  <= ecc_off_d;
      rsp_m_q    <= rsp_m_d;
      ack_tog_q  <= ack_tog_d;
      go_q       <= go_d;
      grant_q    <= grant_d;
    end
  end

  // OTP store: erased at power-on, bits only fall on program
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 1024; i++) otp_mem[i] <= `SFWP_OTP_ERASED;
    end else if (otp_we) begin
      otp_mem[otp_wa] <= otp_wd;
    end
  end

  // Outputs straight from flops
  assign cmd_ready   = ready_q;
  assign rsp_valid   = rv_q;
  assign rsp         = rsp_l_q;
  assign stat        = st_q;
  assign array_go    = go_q;
  assign array_grant = grant_q;

endmodule // sfwp_protect
`default_nettype wire
